/* dsf_pkg.sv */
// Constants, frame layout and carrier types of the serial frame port.
// Shared by the frame port module and by whatever binds to it.
package dsf_pkg;

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int WORD_BITS = 24;
    localparam int CRC_BITS = 8;
    localparam int BC_W = 6;
    localparam logic [BC_W-1:0] BC_LAST_WORD = 6'h17;
    localparam logic [BC_W-1:0] BC_LAST_FRAME = 6'h1F;
    localparam logic [BC_W-1:0] BC_FULL = 6'h20;

    typedef struct packed {
        logic slip;
        logic [1:0] dev_addr;
        logic [4:0] reg_addr;
        logic [15:0] data;
        logic [7:0] crc;
    } dsf_frame_s;

    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] CRC_ZERO = 8'h00;
    localparam logic [7:0] PAD_BYTE = 8'h00;

    // ----------------------------------------
    // Frame register addresses and keys
    // ----------------------------------------
    localparam logic [4:0] FA_DAC_DATA = 5'h01;
    localparam logic [4:0] FA_OUT_CFG = 5'h06;
    localparam logic [4:0] FA_GP_CFG1 = 5'h07;
    localparam logic [4:0] FA_KEY = 5'h08;
    localparam logic [15:0] KEY_SW_RESET = 16'h15FA;
    localparam logic [15:0] KEY_CAL_REFRESH = 16'hFCBA;
    localparam logic [15:0] MID_CODE = 16'h8000;
    localparam logic [15:0] CODE_RST = 16'h0000;

    // Output configuration fields in frame data
    localparam int OC_RANGE_LSB = 0;
    localparam int OC_RANGE_MSB = 3;
    localparam int OC_CUR_BIT = 4;
    localparam int OC_OVR_BIT = 5;
    localparam int OC_EN_BIT = 6;
    localparam int GP_PULLDN_BIT = 0;
    localparam int GP_NEGOFS_BIT = 1;

    // Span codes
    localparam logic [3:0] V_0_5 = 4'h0;
    localparam logic [3:0] V_PM5 = 4'h1;
    localparam logic [3:0] V_0_10 = 4'h2;
    localparam logic [3:0] V_PM10 = 4'h3;
    localparam logic [3:0] C_0_20 = 4'h0;
    localparam logic [3:0] C_0_24 = 4'h1;
    localparam logic [3:0] C_4_20 = 4'h2;
    localparam logic [3:0] C_PM20 = 4'h3;
    localparam logic [3:0] C_PM24 = 4'h4;
    localparam logic [3:0] C_M1_22 = 4'h5;
    localparam logic [3:0] NUM_V_RANGES = 4'h4;
    localparam logic [3:0] NUM_C_RANGES = 4'h6;

    typedef struct packed {
        logic en;
        logic cur_mode;
        logic ovr;
        logic neg_ofs;
        logic pulldn;
        logic [3:0] range;
    } dsf_out_cfg_s;

    localparam dsf_out_cfg_s OUT_CFG_RST = dsf_out_cfg_s'(9'h000);

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int GUARD_US = 100;
    localparam int CAL_US = 500;
    localparam int GUARD_CYC = GUARD_US * CLK_MHZ;
    localparam int CAL_CYC = CAL_US * CLK_MHZ;
    localparam int WAIT_W = 16;
    localparam int WAIT_MAX = (1 << WAIT_W) - 1;

    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_GUARD = 4'h2,
        ST_IDLE = 4'h4,
        ST_CAL = 4'h8
    } dsf_seq_e;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] RA_CTRL = 4'h0;
    localparam logic [3:0] RA_STATUS = 4'h4;
    localparam logic [3:0] RA_CODE = 4'h8;
    localparam logic [3:0] RA_CFG = 4'hC;
    localparam int CTRL_CRC_BIT = 0;
    localparam logic CRC_EN_RST = 1'b1;
    localparam int SB_IN_RESET = 0;
    localparam int SB_GUARD = 1;
    localparam int SB_CAL = 2;
    localparam int SB_CRC_ERR = 3;
    localparam int SB_EARLY = 4;
    localparam int SB_ADDR_MISS = 5;
    localparam logic [8:0] SYNC_RST = 9'h009;

endpackage

/* dsf_serial_frame.sv */
// Serial frame port, reset sequencer and output configuration of the converter.
// Assumes a host drives frames on sclk and an active-low frame select;
// clk_in is a free-running system clock unrelated to sclk.
//
// Operation
// - CRC on (reset default): 32-bit frame shifted in MSB first.
// - Serial data sampled on the falling serial clock edge.
// - CRC off: 24-bit word used; trailing 8 bits of a 32-bit frame ignored.
// - Frame: slip bit, device address, register address, 16 data bits, CRC byte.
// - Converter data is always straight binary; dac_offset_code_out has its top bit flipped on bipolar spans.
// - Symmetric span: code 0 is minus full scale, 0x8000 is zero.
// - Current and voltage output never enabled together.
// - Six current spans and four voltage spans selectable.
// - Overrange on voltage spans; negative offset on unipolar voltage spans.
// - Serial port works with serial clock up to 50 MHz.
// - Output not updated from new data while load pin is high.
// - After any reset outputs disabled and pull-down switch open.
// - Held in reset while supply monitors report low voltage.
// - Reset pin or software reset command resets the device.
`timescale 1ns/1ps

module dsf_serial_frame #(
    parameter int GUARD_CYCLES = dsf_pkg::GUARD_CYC,
    parameter int CAL_CYCLES = dsf_pkg::CAL_CYC
) (
    // System clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Serial link
    input wire logic sclk_in,
    input wire logic frame_sel_n_in,
    input wire logic sdi_in,
    // Pins and supply monitors
    input wire logic load_converter_n_in,
    input wire logic reset_pin_n_in,
    input wire logic logic_supply_ok_in,
    input wire logic analog_supply_ok_in,
    input wire logic [1:0] dev_addr_pins_in,
    // Register port
    input wire logic [dsf_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Converter side
    output logic [15:0] dac_code_out,
    output logic [15:0] dac_offset_code_out,
    output dsf_pkg::dsf_out_cfg_s out_cfg_out,
    output logic current_en_out,
    output logic voltage_en_out,
    output logic neg_offset_en_out,
    output logic dev_reset_out
);
    import dsf_pkg::*;

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (GUARD_CYCLES < 1 || GUARD_CYCLES > WAIT_MAX) begin : g_chk_guard
        $error("GUARD_CYCLES out of range");
    end
    if (CAL_CYCLES < 1 || CAL_CYCLES > WAIT_MAX) begin : g_chk_cal
        $error("CAL_CYCLES out of range");
    end

    localparam logic [WAIT_W-1:0] GUARD_LOAD = WAIT_W'(GUARD_CYCLES - 1);
    localparam logic [WAIT_W-1:0] CAL_LOAD = WAIT_W'(CAL_CYCLES - 1);
    localparam int NSYNC = 9;

    // ----------------------------------------
    // Link domain: shift register
    // ----------------------------------------
    logic link_clr_n;
    logic [FRAME_BITS-1:0] shift_r;
    logic [FRAME_BITS-1:0] shift_nxt;
    logic [BC_W-1:0] bit_cnt_r;
    logic [WORD_BITS-1:0] word24_r;
    logic [FRAME_BITS-1:0] word32_r;
    logic tog24_r;
    logic tog32_r;

    // Select high clears the count with no sclk edge, since sclk may stop
    assign link_clr_n = arst_n_in & ~frame_sel_n_in;
    assign shift_nxt = {shift_r[FRAME_BITS-2:0], sdi_in};

    // Only a shift, a count increment and a compare per edge, short enough for 50 MHz
    always_ff @(negedge sclk_in or negedge link_clr_n) begin
        if (!link_clr_n) begin
            shift_r <= '0;
            bit_cnt_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            if (bit_cnt_r != BC_FULL) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // Snapshots stay still until the next frame reaches the same bit
    always_ff @(negedge sclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            word24_r <= '0;
            word32_r <= '0;
            tog24_r <= 1'b0;
            tog32_r <= 1'b0;
        end else begin
            if (bit_cnt_r == BC_LAST_WORD) begin
                word24_r <= shift_nxt[WORD_BITS-1:0];
                tog24_r <= ~tog24_r;
            end
            if (bit_cnt_r == BC_LAST_FRAME) begin
                word32_r <= shift_nxt;
                tog32_r <= ~tog32_r;
            end
        end
    end

    // ----------------------------------------
    // Synchronisers into clk_in
    // ----------------------------------------
    logic [NSYNC-1:0] async_vec;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic s_sel_n;
    logic s_tog24;
    logic s_tog32;
    logic s_load_n;
    logic s_rst_pin_n;
    logic s_logic_ok;
    logic s_analog_ok;
    logic [1:0] s_dev_addr;

    assign async_vec = {dev_addr_pins_in, analog_supply_ok_in, logic_supply_ok_in,
                        reset_pin_n_in, load_converter_n_in, tog32_r, tog24_r,
                        frame_sel_n_in};

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                meta_r[i] <= SYNC_RST[i];
                sync_r[i] <= SYNC_RST[i];
            end else begin
                meta_r[i] <= async_vec[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end

    assign {s_dev_addr, s_analog_ok, s_logic_ok, s_rst_pin_n, s_load_n,
            s_tog32, s_tog24, s_sel_n} = sync_r;

    // ----------------------------------------
    // Frame boundary tracking
    // ----------------------------------------
    logic sel_d_r;
    logic tog24_d_r;
    logic tog32_d_r;
    logic got24_r;
    logic got32_r;
    logic frame_end_r;
    logic sel_rise;
    logic sel_fall;

    assign sel_rise = s_sel_n & ~sel_d_r;
    assign sel_fall = ~s_sel_n & sel_d_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_d_r <= 1'b1;
            tog24_d_r <= 1'b0;
            tog32_d_r <= 1'b0;
            frame_end_r <= 1'b0;
        end else begin
            sel_d_r <= s_sel_n;
            tog24_d_r <= s_tog24;
            tog32_d_r <= s_tog32;
            // One cycle late so a toggle landing with the edge is seen
            frame_end_r <= sel_rise;
        end
    end

    // Bit-count marks; a new mark wins over the clear at frame start
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            got24_r <= 1'b0;
            got32_r <= 1'b0;
        end else begin
            got24_r <= (got24_r & ~sel_fall) | (s_tog24 ^ tog24_d_r);
            got32_r <= (got32_r & ~sel_fall) | (s_tog32 ^ tog32_d_r);
        end
    end

    // ----------------------------------------
    // Frame decode
    // ----------------------------------------
    function automatic logic [CRC_BITS-1:0] crc8(input logic [WORD_BITS-1:0] d);
        logic [CRC_BITS-1:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = WORD_BITS - 1; i >= 0; i--) begin
            fb = c[CRC_BITS-1] ^ d[i];
            c = {c[CRC_BITS-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_ZERO);
        end
        return c;
    endfunction

    dsf_seq_e state_r;
    logic crc_en_r;
    logic frame_done;
    logic [FRAME_BITS-1:0] frame_word;
    dsf_frame_s frame;
    logic crc_ok;
    logic addr_ok;
    logic cmd_ok;
    logic cmd_take;
    logic is_key;
    logic cal_cmd;

    assign frame_done = frame_end_r & (crc_en_r ? got32_r : got24_r);
    assign frame_word = crc_en_r ? word32_r : {word24_r, PAD_BYTE};
    assign frame = dsf_frame_s'(frame_word);
    assign crc_ok = crc8(frame_word[FRAME_BITS-1:CRC_BITS]) == frame.crc;
    assign addr_ok = frame.dev_addr == s_dev_addr;
    assign cmd_ok = frame_done & addr_ok & (~crc_en_r | crc_ok);
    // Commands in the guard window are dropped and flagged
    assign cmd_take = cmd_ok & ((state_r == ST_IDLE) | (state_r == ST_CAL));
    assign is_key = cmd_take & (frame.reg_addr == FA_KEY);
    assign cal_cmd = is_key & (frame.data == KEY_CAL_REFRESH) & (state_r == ST_IDLE);

    // ----------------------------------------
    // Reset generation and sequencer
    // ----------------------------------------
    logic supply_bad;
    logic rst_req;
    logic sw_rst_r;
    logic [WAIT_W-1:0] wait_r;

    assign supply_bad = ~s_logic_ok | ~s_analog_ok;
    assign rst_req = supply_bad | ~s_rst_pin_n | sw_rst_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sw_rst_r <= 1'b0;
        end else begin
            sw_rst_r <= is_key & (frame.data == KEY_SW_RESET);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= ST_RESET;
            wait_r <= '0;
        end else if (rst_req) begin
            state_r <= ST_RESET;
            wait_r <= GUARD_LOAD;
        end else begin
            unique case (state_r)
                ST_RESET: begin
                    state_r <= ST_GUARD;
                    wait_r <= GUARD_LOAD;
                end
                ST_GUARD: begin
                    if (wait_r == '0) begin
                        state_r <= ST_IDLE;
                    end else begin
                        wait_r <= wait_r - 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (cal_cmd) begin
                        state_r <= ST_CAL;
                        wait_r <= CAL_LOAD;
                    end
                end
                ST_CAL: begin
                    if (wait_r == '0) begin
                        state_r <= ST_IDLE;
                    end else begin
                        wait_r <= wait_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_RESET;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Output configuration
    // ----------------------------------------
    dsf_out_cfg_s cfg_r;
    logic [15:0] input_code_r;
    logic new_cur;
    logic [3:0] new_range;
    logic range_legal;
    logic bipolar;

    assign new_cur = frame.data[OC_CUR_BIT];
    assign new_range = frame.data[OC_RANGE_MSB:OC_RANGE_LSB];
    assign range_legal = new_cur ? (new_range < NUM_C_RANGES)
                                 : (new_range < NUM_V_RANGES);
    assign bipolar = cfg_r.cur_mode ? (cfg_r.range == C_PM20) | (cfg_r.range == C_PM24)
                                    : (cfg_r.range == V_PM5) | (cfg_r.range == V_PM10);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_r <= OUT_CFG_RST;
            input_code_r <= CODE_RST;
        end else if (rst_req) begin
            cfg_r <= OUT_CFG_RST;
            input_code_r <= CODE_RST;
        end else if (cmd_take) begin
            if (frame.reg_addr == FA_DAC_DATA) begin
                input_code_r <= frame.data;
            end
            if (frame.reg_addr == FA_OUT_CFG && range_legal) begin
                cfg_r.en <= frame.data[OC_EN_BIT];
                cfg_r.cur_mode <= new_cur;
                cfg_r.range <= new_range;
                cfg_r.ovr <= frame.data[OC_OVR_BIT] & ~new_cur;
            end
            if (frame.reg_addr == FA_GP_CFG1) begin
                cfg_r.pulldn <= frame.data[GP_PULLDN_BIT];
                cfg_r.neg_ofs <= frame.data[GP_NEGOFS_BIT];
            end
        end
    end

    // Single mode bit makes both enables at once impossible
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            current_en_out <= 1'b0;
            voltage_en_out <= 1'b0;
            neg_offset_en_out <= 1'b0;
        end else if (rst_req) begin
            current_en_out <= 1'b0;
            voltage_en_out <= 1'b0;
            neg_offset_en_out <= 1'b0;
        end else begin
            current_en_out <= cfg_r.en & cfg_r.cur_mode;
            voltage_en_out <= cfg_r.en & ~cfg_r.cur_mode;
            neg_offset_en_out <= cfg_r.neg_ofs & ~cfg_r.cur_mode & ~bipolar;
        end
    end

    assign out_cfg_out = cfg_r;

    // ----------------------------------------
    // Converter code and load control
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dac_code_out <= CODE_RST;
            dac_offset_code_out <= CODE_RST;
        end else if (rst_req) begin
            dac_code_out <= CODE_RST;
            dac_offset_code_out <= CODE_RST;
        end else if (!s_load_n) begin
            dac_code_out <= input_code_r;
            // Signed step count from zero; flipping the top bit recentres
            dac_offset_code_out <= bipolar ? (input_code_r ^ MID_CODE) : input_code_r;
        end
    end

    assign dev_reset_out = state_r == ST_RESET;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    logic crc_err_r;
    logic early_r;
    logic addr_miss_r;
    logic stat_clr;
    logic [31:0] rd_val;

    assign stat_clr = reg_wr_in & (reg_addr_in == RA_STATUS);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crc_en_r <= CRC_EN_RST;
        end else if (rst_req) begin
            crc_en_r <= CRC_EN_RST;
        end else if (reg_wr_in && reg_addr_in == RA_CTRL) begin
            crc_en_r <= reg_wdata_in[CTRL_CRC_BIT];
        end
    end

    // Sticky flags: a new event wins over a write-one clear
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crc_err_r <= 1'b0;
            early_r <= 1'b0;
            addr_miss_r <= 1'b0;
        end else begin
            crc_err_r <= (crc_err_r & ~(stat_clr & reg_wdata_in[SB_CRC_ERR]))
                       | (frame_done & addr_ok & crc_en_r & ~crc_ok);
            early_r <= (early_r & ~(stat_clr & reg_wdata_in[SB_EARLY]))
                     | (cmd_ok & (state_r == ST_GUARD));
            addr_miss_r <= (addr_miss_r & ~(stat_clr & reg_wdata_in[SB_ADDR_MISS]))
                         | (frame_done & ~addr_ok);
        end
    end

    always_comb begin
        rd_val = '0;
        unique case (reg_addr_in)
            RA_CTRL: begin
                rd_val[CTRL_CRC_BIT] = crc_en_r;
            end
            RA_STATUS: begin
                rd_val[SB_IN_RESET] = state_r == ST_RESET;
                rd_val[SB_GUARD] = state_r == ST_GUARD;
                rd_val[SB_CAL] = state_r == ST_CAL;
                rd_val[SB_CRC_ERR] = crc_err_r;
                rd_val[SB_EARLY] = early_r;
                rd_val[SB_ADDR_MISS] = addr_miss_r;
            end
            RA_CODE: begin
                rd_val = {dac_code_out, input_code_r};
            end
            RA_CFG: begin
                rd_val[$bits(dsf_out_cfg_s)-1:0] = cfg_r;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_val : '0;
        end
    end

endmodule

/* dsf_serial_frame_properties.sv */
// Port-level checker for the serial frame port.
// Bound to dsf_serial_frame; sees only its ports, one clock domain.
`timescale 1ns/1ps
module dsf_serial_frame_properties (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Watched inputs
    input wire logic frame_sel_n_in,
    input wire logic load_converter_n_in,
    input wire logic reset_pin_n_in,
    input wire logic logic_supply_ok_in,
    input wire logic analog_supply_ok_in,
    // Watched outputs
    input wire logic [15:0] dac_code_out,
    input wire dsf_pkg::dsf_out_cfg_s out_cfg_out,
    input wire logic current_en_out,
    input wire logic voltage_en_out,
    input wire logic neg_offset_en_out,
    input wire logic dev_reset_out
);
    import dsf_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_mode_excl:
        assert property (!(current_en_out && voltage_en_out)) else $error("both modes on");
    a_enable_track:
        assert property (!dev_reset_out && !$past(dev_reset_out) |->
            current_en_out == $past(out_cfg_out.en && out_cfg_out.cur_mode) &&
            voltage_en_out == $past(out_cfg_out.en && !out_cfg_out.cur_mode))
        else $error("enable does not follow config");
    a_span_legal:
        assert property (out_cfg_out.range <
            (out_cfg_out.cur_mode ? NUM_C_RANGES : NUM_V_RANGES)) else $error("bad span");
    a_ovr_voltage:
        assert property (out_cfg_out.cur_mode |-> !out_cfg_out.ovr) else $error("ovr in current");
    a_negofs_gate:
        assert property (neg_offset_en_out |-> $past(out_cfg_out.neg_ofs) &&
            !$past(out_cfg_out.cur_mode) && !$past(out_cfg_out.range[0]))
        else $error("offset on wrong span");
    a_load_freeze:
        assert property (load_converter_n_in && $past(load_converter_n_in, 3) &&
            !dev_reset_out && !$past(dev_reset_out) |-> $stable(dac_code_out))
        else $error("code moved while load high");
    a_reset_clear:
        assert property ($fell(dev_reset_out) |-> ##1 out_cfg_out == OUT_CFG_RST &&
            !current_en_out && !voltage_en_out) else $error("outputs alive after reset");
    a_supply_reset:
        assert property ((!logic_supply_ok_in || !analog_supply_ok_in) [*5] |-> dev_reset_out)
        else $error("no reset on low supply");
    a_pin_reset:
        assert property (!reset_pin_n_in [*5] |-> dev_reset_out) else $error("no pin reset");
    a_cfg_after_frame:
        assert property (!$stable(out_cfg_out) && !dev_reset_out && !$past(dev_reset_out) |->
            frame_sel_n_in && $past(frame_sel_n_in, 2)) else $error("config moved mid frame");
endmodule

bind dsf_serial_frame dsf_serial_frame_properties u_props (
    .clk_in, .arst_n_in, .frame_sel_n_in, .load_converter_n_in, .reset_pin_n_in,
    .logic_supply_ok_in, .analog_supply_ok_in, .dac_code_out, .out_cfg_out,
    .current_en_out, .voltage_en_out, .neg_offset_en_out, .dev_reset_out);

/* dsf_host_model.sv */
// Host side of the serial link: frames one word and shifts it out.
// Link clock stands low between frames; 32 ns period within them.
`timescale 1ns/1ps
module dsf_host_model (
    // Serial link
    output logic sclk_out,
    output logic frame_sel_n_out,
    output logic sdi_out
);
    import dsf_pkg::*;
    initial begin
        sclk_out = 1'b0;
        frame_sel_n_out = 1'b1;
        sdi_out = 1'b0;
    end

    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // Bad flips one CRC bit; short counts cut the frame
    task automatic send(input logic [1:0] da, input logic [4:0] ra, input logic [15:0] d,
                        input int nbits, input logic bad);
        logic [31:0] w;
        w[31:8] = {1'b0, da, ra, d};
        w[7:0] = crc8(w[31:8]) ^ {7'h00, bad};
        #7 frame_sel_n_out = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            sdi_out = w[i];
            #8 sclk_out = 1'b1;
            #16 sclk_out = 1'b0;
            #8;
        end
        #32 frame_sel_n_out = 1'b1;
        sdi_out = ~sdi_out;
        #300;
    endtask
endmodule

/* dsf_serial_frame_test.sv */
// Self-checking bench for the serial frame port.
// Host model drives the link; register port and pins are driven here.
`timescale 1ns/1ps
module dsf_serial_frame_test;
    import dsf_pkg::*;
    logic clk_in, arst_n_in, load_n, pin_n, lsup, asup, wr, rd;
    logic [3:0] ra;
    logic [31:0] wd, rdata, rv;
    logic [15:0] code, offs;
    dsf_out_cfg_s cfg;
    logic cur_en, volt_en, neg_en, dev_rst, cur;
    logic [3:0] rng;
    wire sclk, sel_n, sdi;
    int n_fail = 0;
    int compares = 0;

    dsf_host_model host (.sclk_out(sclk), .frame_sel_n_out(sel_n), .sdi_out(sdi));
    // Short guard and calibration counts keep the run brief
    dsf_serial_frame #(.GUARD_CYCLES(20), .CAL_CYCLES(60)) DUT (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .sclk_in(sclk), .frame_sel_n_in(sel_n),
        .sdi_in(sdi), .load_converter_n_in(load_n), .reset_pin_n_in(pin_n),
        .logic_supply_ok_in(lsup), .analog_supply_ok_in(asup), .dev_addr_pins_in(2'b10),
        .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .dac_code_out(code), .dac_offset_code_out(offs),
        .out_cfg_out(cfg), .current_en_out(cur_en), .voltage_en_out(volt_en),
        .neg_offset_en_out(neg_en), .dev_reset_out(dev_rst));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic test_done;
        $display("compares %0d, n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(posedge clk_in);
        d = rdata;
    endtask

    // Polls status until reset, guard and calibration are over
    task automatic wait_idle;
        int i = 0;
        rv = '1;
        while (i < 300 && rv[2:0] !== 3'b000) begin
            reg_rd(RA_STATUS, rv);
            i++;
        end
        if (rv[2:0] !== 3'b000) begin
            n_fail++;
            test_done();
        end
    endtask

    initial begin
        {arst_n_in, load_n, pin_n, lsup, asup, wr, rd} = 7'b0011100;
        {ra, wd} = '0;
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        reg_rd(RA_CTRL, rv);
        chk(rv[CTRL_CRC_BIT], 1'b1);
        reg_rd(4'h2, rv);
        chk(rv, 32'h0000_0000);
        wait_idle();
        host.send(2'b10, FA_KEY, KEY_CAL_REFRESH, 32, 1'b0);
        reg_rd(RA_STATUS, rv);
        chk(rv[SB_CAL], 1'b1);
        wait_idle();
        for (int i = 0; i < 10; i++) begin
            cur = i < 6;
            rng = cur ? 4'(i) : 4'(i - 6);
            host.send(2'b10, FA_OUT_CFG, {9'h000, 2'b10, cur, rng}, 32, 1'b0);
            chk({cfg.cur_mode, cfg.range, cur_en, volt_en}, {cur, rng, cur, !cur});
        end
        host.send(2'b10, FA_OUT_CFG, 16'h0056, 32, 1'b0);
        chk(cfg, 9'h103);
        host.send(2'b10, FA_OUT_CFG, 16'h0060, 32, 1'b0);
        host.send(2'b10, FA_GP_CFG1, 16'h0002, 32, 1'b0);
        chk({cfg, neg_en}, {9'h160, 1'b1});
        host.send(2'b10, FA_OUT_CFG, 16'h0041, 32, 1'b0);
        host.send(2'b10, FA_DAC_DATA, MID_CODE, 32, 1'b0);
        chk({code, offs}, {16'h8000, 16'h0000});
        @(posedge clk_in);
        load_n <= 1'b1;
        host.send(2'b10, FA_DAC_DATA, 16'h1234, 32, 1'b0);
        chk(code, 16'h8000);
        reg_rd(RA_CODE, rv);
        chk(rv, 32'h8000_1234);
        load_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        chk(code, 16'h1234);
        host.send(2'b01, FA_DAC_DATA, 16'h5555, 32, 1'b0);
        host.send(2'b10, FA_DAC_DATA, 16'h5555, 32, 1'b1);
        host.send(2'b10, FA_DAC_DATA, 16'h5555, 31, 1'b0);
        chk(code, 16'h1234);
        reg_rd(RA_STATUS, rv);
        chk(rv[5:3], 3'b101);
        reg_wr(RA_CTRL, 32'h0000_0000);
        host.send(2'b10, FA_DAC_DATA, 16'h0ABC, 24, 1'b0);
        chk(code, 16'h0ABC);
        host.send(2'b10, FA_DAC_DATA, 16'h0DEF, 32, 1'b1);
        chk(code, 16'h0DEF);
        host.send(2'b10, FA_GP_CFG1, 16'h0001, 24, 1'b0);
        chk(cfg.pulldn, 1'b1);
        host.send(2'b10, FA_KEY, KEY_SW_RESET, 24, 1'b0);
        chk({cfg, cur_en, volt_en, code}, 27'h0);
        wait_idle();
        @(posedge clk_in);
        pin_n <= 1'b0;
        repeat (6) @(posedge clk_in);
        chk(dev_rst, 1'b1);
        pin_n <= 1'b1;
        wait_idle();
        for (int k = 0; k < 2; k++) begin
            {lsup, asup} <= k ? 2'b10 : 2'b01;
            repeat (6) @(posedge clk_in);
            chk(dev_rst, 1'b1);
            {lsup, asup} <= 2'b11;
            wait_idle();
        end
        test_done();
    end
endmodule
